// [hw/bus_wake_status_regs.sv]
// Purpose: Bus fault and wake source status registers with transceiver recovery
// Assumes: Serial frames decoded outside; inputs synchronous to clk_i
// Notes:   Read data is registered, valid one cycle after the read strobe

`timescale 1ns/1ps

module bus_wake_status_regs import bus_wake_pkg::*; #(
	parameter int TX_EN_TIME_NS = TX_EN_TIME_NS_DEF
) (
	// Clock and reset
	input  wire logic      clk_i,
	input  wire logic      resetn_i,
	// Register access from the serial decoder
	input  wire reg_acc_t  acc_i,
	output logic [15:0]    rd_data_o,
	// Reset and mode events
	input  wire logic      soft_reset_i,
	input  wire logic      restart_i,
	input  wire logic      fail_safe_entry_i,
	input  wire pwr_mode_t pwr_mode_i,
	input  wire trx_mode_t trx_mode_i,
	// Selective wake
	input  wire logic      selective_wake_enable_i,
	input  wire logic      bus_silence_indication_i,
	input  wire logic      sw_config_error_i,
	input  wire logic [5:0] sw_error_count_i,
	input  wire logic      silence_timeout_irq_mask_i,
	input  wire logic      interrupt_out_n_i,
	output logic           irq_request_o,
	// Transceiver faults
	input  wire logic      transceiver_thermal_shutdown_i,
	input  wire logic      transmit_dominant_timeout_i,
	input  wire logic      bus_dominant_timeout_i,
	input  wire logic      txd_i,
	input  wire logic      bus_recessive_i,
	input  wire logic      supply_below_threshold_i,
	output logic           tx_enable_o,
	// Wake sources
	input  wire wake_ev_t  wake_ev_i
);

	// ==========================================================
	// Timing and elaboration check
	localparam int TX_EN_CYC_RAW = (TX_EN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TX_EN_CYC     = (TX_EN_CYC_RAW < 1) ? 1 : TX_EN_CYC_RAW;

	if (TX_EN_TIME_NS < 1 || TX_EN_CYC > 4096) begin : g_bad
		$error("TX_EN_TIME_NS out of range");
	end

	// ==========================================================
	// State
	logic [BUS_FLAG_W-1:0] bus_reg, bus_next;      // Bus fault flags
	logic [WAKE_N-1:0]     wake_reg, wake_next;    // Wake source flags
	logic                  lock_reg, lock_next;    // Timeout clear blocked
	logic                  sil_reg, sil_next;      // Previous silence level
	logic                  tsd_reg, tsd_next;      // Previous thermal level
	logic                  interrupt_out_n_reg, interrupt_out_n_next;    // Previous interrupt pin
	logic                  txdto_reg, txdto_next;  // Transmit timeout active
	logic                  busto_reg, busto_next;  // Bus timeout active
	tx_state_t             st_reg, st_next;        // Transmitter state
	logic                  txen_reg, txen_next;
	logic                  irq_reg, irq_next;
	logic [15:0]           rd_reg, rd_next;

	// ==========================================================
	// Decode and events
	logic        clr_bus, clr_wake;  // Host clear strobes
	logic        rd_req;
	logic        sil_rise, interrupt_out_n_fall, tsd_rise;
	logic        timeout_set;        // Silence timeout event
	logic        uv_cond;            // Gated undervoltage
	logic        passive_mode;       // Wake-capable or off
	logic        fault_any;
	logic        rec_done;
	logic [15:0] wake_vec;           // Wake flags at their positions

	assign clr_bus      = acc_i.valid && acc_i.write && (acc_i.addr == ADDR_BUS_FAULT);
	assign clr_wake     = acc_i.valid && acc_i.write && (acc_i.addr == ADDR_WAKE_SOURCE);
	assign rd_req       = acc_i.valid && !acc_i.write;
	assign sil_rise     = bus_silence_indication_i && !sil_reg;
	assign interrupt_out_n_fall    = interrupt_out_n_reg && !interrupt_out_n_i;
	assign tsd_rise     = transceiver_thermal_shutdown_i && !tsd_reg;
	assign timeout_set  = selective_wake_enable_i && sil_rise;
	assign passive_mode = (trx_mode_i == TRX_WAKE) || (trx_mode_i == TRX_OFF);
	// Comparator result ignored outside active modes, ends as supply recovers
	assign uv_cond      = supply_below_threshold_i &&
	                      ((trx_mode_i == TRX_NORMAL) || (trx_mode_i == TRX_RXONLY));
	assign fault_any    = transceiver_thermal_shutdown_i || txdto_reg || busto_reg ||
	                      uv_cond;

	// Place wake flags at their register bit positions
	always_comb begin
		wake_vec = 16'h0000;
		for (int i = 0; i < WAKE_N; i++) begin
			wake_vec[WAKE_BIT[i]] = wake_reg[i];
		end
	end

	// ==========================================================
	// Recovery timer, runs only while waiting to re-enable
	tx_recovery_timer #(
		.CYCLES (TX_EN_CYC)
	) u_timer (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.run_i    (st_reg == ST_RECOVER),
		.txd_i    (txd_i),
		.done_o   (rec_done)
	);

	// ==========================================================
	// Status flag next values: clear first, set afterwards so set wins
	always_comb begin
		bus_next  = bus_reg;
		wake_next = wake_reg;
		lock_next = lock_reg;
		// Host clears; flags never drop on their own
		if (clr_bus) begin
			if (acc_i.data[TIMEOUT_BIT] && !lock_reg) begin
				bus_next[TIMEOUT_BIT] = 1'b0;
			end
			if (acc_i.data[SELECTIVE_WAKE_SYSTEM_ERROR_BIT]) begin
				bus_next[SELECTIVE_WAKE_SYSTEM_ERROR_BIT] = 1'b0;
			end
			if (acc_i.data[CODE_HI] || acc_i.data[CODE_LO]) begin
				bus_next[CODE_HI:CODE_LO] = CODE_NONE;
			end
			if (acc_i.data[UV_BIT]) begin
				bus_next[UV_BIT] = 1'b0;
			end
		end
		for (int i = 0; i < WAKE_N; i++) begin
			if (clr_wake && acc_i.data[WAKE_BIT[i]]) begin
				wake_next[i] = 1'b0;
			end
		end
		// Lock released by interrupt falling edge, re-armed by a new set
		if (interrupt_out_n_fall) begin
			lock_next = 1'b0;
		end
		// Sets after clears
		if (timeout_set) begin
			bus_next[TIMEOUT_BIT] = 1'b1;
			lock_next             = 1'b1;
		end
		if (selective_wake_enable_i &&
		    (sw_config_error_i || (sw_error_count_i > ERR_CNT_LIMIT))) begin
			bus_next[SELECTIVE_WAKE_SYSTEM_ERROR_BIT] = 1'b1;
		end
		// Simultaneous causes: highest code reported
		if (bus_dominant_timeout_i) begin
			bus_next[CODE_HI:CODE_LO] = CODE_BUS_DOM;
		end else if (transmit_dominant_timeout_i) begin
			bus_next[CODE_HI:CODE_LO] = CODE_TXD_DOM;
		end else if (tsd_rise) begin
			bus_next[CODE_HI:CODE_LO] = CODE_THERMAL;
		end
		if (uv_cond) begin
			bus_next[UV_BIT] = 1'b1;
		end
		for (int i = 0; i < WAKE_N; i++) begin
			if (wake_ev_i[i]) begin
				wake_next[i] = 1'b1;
			end
		end
		// Restart keeps only the masked positions
		if (restart_i) begin
			bus_next = bus_next & BUS_RESTART_KEEP[BUS_FLAG_W-1:0];
			for (int i = 0; i < WAKE_N; i++) begin
				if (!WAKE_RESTART_KEEP[WAKE_BIT[i]]) begin
					wake_next[i] = 1'b0;
				end
			end
		end
		// Fail-safe entry wipes wake flags, even a same-cycle event
		if (fail_safe_entry_i) begin
			wake_next = '0;
		end
		if (soft_reset_i) begin
			bus_next  = BUS_RESET_VAL[BUS_FLAG_W-1:0];
			wake_next = '0;
			lock_next = 1'b0;
		end
	end

	// ==========================================================
	// Transceiver fault conditions and transmitter state
	always_comb begin
		txdto_next = txdto_reg;
		busto_next = busto_reg;
		st_next    = st_reg;
		if (txd_i || passive_mode) begin
			txdto_next = 1'b0;
		end
		if (transmit_dominant_timeout_i) begin
			txdto_next = 1'b1;
		end
		if (bus_recessive_i || passive_mode) begin
			busto_next = 1'b0;
		end
		if (bus_dominant_timeout_i) begin
			busto_next = 1'b1;
		end
		unique case (st_reg)
			ST_RUN: begin
				if (fault_any) begin
					st_next = ST_FAULT;
				end
			end
			ST_FAULT: begin
				if (!fault_any) begin
					st_next = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (fault_any) begin
					st_next = ST_FAULT;
				end else if (rec_done) begin
					st_next = ST_RUN;
				end
			end
			default: begin
				st_next = ST_FAULT;  // Illegal code: stay silent
			end
		endcase
		txen_next = (st_next == ST_RUN) && !fault_any;
	end

	// ==========================================================
	// Interrupt request, read data and edge history
	always_comb begin
		sil_next  = bus_silence_indication_i;
		tsd_next  = transceiver_thermal_shutdown_i;
		interrupt_out_n_next = interrupt_out_n_i;
		// Soft reset wipes the flag in the same cycle, so no request for it
		irq_next  = timeout_set && !bus_reg[TIMEOUT_BIT] && silence_timeout_irq_mask_i &&
		            !soft_reset_i &&
		            ((pwr_mode_i == PM_STOP) || (pwr_mode_i == PM_NORMAL));
		rd_next   = rd_reg;
		if (rd_req) begin
			if (acc_i.addr == ADDR_BUS_FAULT) begin
				rd_next = {11'h000, bus_reg};
			end else if (acc_i.addr == ADDR_WAKE_SOURCE) begin
				rd_next = wake_vec;
			end else begin
				rd_next = 16'h0000;  // Unmapped reads zero
			end
		end
	end

	// ==========================================================
	// Registers only
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bus_reg   <= BUS_RESET_VAL[BUS_FLAG_W-1:0];
			wake_reg  <= '0;
			lock_reg  <= 1'b0;
			sil_reg   <= 1'b0;
			tsd_reg   <= 1'b0;
			interrupt_out_n_reg  <= 1'b1;
			txdto_reg <= 1'b0;
			busto_reg <= 1'b0;
			st_reg    <= ST_RUN;
			txen_reg  <= 1'b1;
			irq_reg   <= 1'b0;
			rd_reg    <= 16'h0000;
		end else begin
			bus_reg   <= bus_next;
			wake_reg  <= wake_next;
			lock_reg  <= lock_next;
			sil_reg   <= sil_next;
			tsd_reg   <= tsd_next;
			interrupt_out_n_reg  <= interrupt_out_n_next;
			txdto_reg <= txdto_next;
			busto_reg <= busto_next;
			st_reg    <= st_next;
			txen_reg  <= txen_next;
			irq_reg   <= irq_next;
			rd_reg    <= rd_next;
		end
	end

	assign rd_data_o     = rd_reg;
	assign irq_request_o = irq_reg;
	assign tx_enable_o   = txen_reg;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	AST_RSVD_ZERO: assert property (
		rd_req && acc_i.addr == ADDR_BUS_FAULT |=> rd_data_o[15:5] == 11'h000)
		else $error("reserved bus status bits not zero");
	AST_TIMEOUT_SET: assert property (
		selective_wake_enable_i && $rose(bus_silence_indication_i) && !soft_reset_i
		|=> bus_reg[TIMEOUT_BIT])
		else $error("silence timeout flag not set");
	AST_TIMEOUT_GATED: assert property (
		$rose(bus_reg[TIMEOUT_BIT]) |-> $past(selective_wake_enable_i))
		else $error("silence timeout set without selective wake");
	AST_UV_TX_OFF: assert property (
		uv_cond && !soft_reset_i |=> !tx_enable_o && bus_reg[UV_BIT])
		else $error("transmitter on during undervoltage");
	AST_UV_MODE: assert property (
		$rose(bus_reg[UV_BIT]) |-> $past(trx_mode_i) inside {TRX_NORMAL, TRX_RXONLY})
		else $error("undervoltage flagged outside active modes");
	AST_CLEAR_LOCK: assert property (
		bus_reg[TIMEOUT_BIT] && lock_reg && !interrupt_out_n_fall && clr_bus && !soft_reset_i
		|=> bus_reg[TIMEOUT_BIT])
		else $error("locked timeout flag was cleared");
	AST_SET_WINS: assert property (
		wake_ev_i.bus_wake_flag && clr_wake && !fail_safe_entry_i && !soft_reset_i
		|=> wake_reg[4])
		else $error("wake event lost to clear");
	AST_FAILSAFE: assert property (
		fail_safe_entry_i |=> wake_reg == '0)
		else $error("wake flags survive fail-safe entry");
	AST_REENABLE: assert property (
		$rose(tx_enable_o) |-> $past(txd_i, 1) && $past(txd_i, 2) && $past(st_reg) == ST_RECOVER)
		else $error("transmitter re-enabled without recessive input");
	AST_IRQ: assert property (
		irq_request_o |-> $past(silence_timeout_irq_mask_i) && $rose(bus_reg[TIMEOUT_BIT]))
		else $error("interrupt without unmasked timeout set");
	AST_TXD_END: assert property (
		txdto_reg && (txd_i || passive_mode) && !transmit_dominant_timeout_i |=> !txdto_reg)
		else $error("transmit timeout not ended");
	AST_SELECTIVE_WAKE_SYSTEM_ERROR: assert property (
		$rose(bus_reg[SELECTIVE_WAKE_SYSTEM_ERROR_BIT]) |-> $past(selective_wake_enable_i))
		else $error("system error set without selective wake");

	COV_RECOVER: cover property (st_reg == ST_RECOVER ##1 st_reg == ST_RUN);
	COV_IRQ: cover property (irq_request_o ##[1:20] interrupt_out_n_fall);
	COV_RESTART: cover property (restart_i && wake_reg != '0);

endmodule : bus_wake_status_regs

// [hw/bus_wake_pkg.sv]
// Purpose: Constants and types for the bus fault and wake source status bank
// Assumes: 7-bit register addresses decoded from the serial frame outside this bank
// Notes:   Shared by the status bank and its transmitter recovery timer
//
// How it works
// - Reserved status bits always read as zero
// - Silence timeout latched at bus status bit 4
// - Selective-wake system error latched at bit 3
// - Failure cause code in bits 2 to 1
// - Supply undervoltage sets bit 0, stops transmitter
// - Soft reset clears all; restart keeps bits 6:0
// - Undervoltage compare only in normal or receive-only
// - Transmit timeout ends: input high, wake-capable, off
// - Bus timeout ends: recessive, wake-capable, off
// - Undervoltage ends when supply back above threshold
// - Retransmit only after input high enable time
// - Silence flag set only with selective wake on
// - Interrupt on silence flag in stop/normal, unmasked
// - System error on config error or count over 32
// - Silence flag clear blocked until interrupt falling edge
// - Wake source flags latched at bits 9,8,7,4,3
// - Restart keeps wake bits 10:7 and 1
// - Fail-safe entry clears whole wake register
// - Flags stay set until host clear, soft reset, restart or fail-safe entry

package bus_wake_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [6:0]  ADDR_BUS_FAULT   = 7'h43;  // Bus fault status
	localparam logic [6:0]  ADDR_WAKE_SOURCE = 7'h44;  // Wake source status

	// ==========================================================
	// Bus fault status field positions (within low 5 bits)
	localparam int          BUS_FLAG_W     = 5;
	localparam int          TIMEOUT_BIT    = 4;  // Silence timeout
	localparam int          SELECTIVE_WAKE_SYSTEM_ERROR_BIT     = 3;  // Selective-wake error
	localparam int          CODE_HI        = 2;  // Failure cause msb
	localparam int          CODE_LO        = 1;  // Failure cause lsb
	localparam int          UV_BIT         = 0;  // Supply undervoltage

	// ==========================================================
	// Wake source flags: index 0..4 = input 4, input 5, timer 1, timer 2, bus
	localparam int          WAKE_N         = 5;
	localparam int          WAKE_BIT [WAKE_N] = '{3, 4, 7, 8, 9};

	// ==========================================================
	// Reset values and restart keep masks
	localparam logic [15:0] BUS_RESET_VAL     = 16'h0000;
	localparam logic [15:0] WAKE_RESET_VAL    = 16'h0000;
	localparam logic [15:0] BUS_RESTART_KEEP  = 16'h007F;
	localparam logic [15:0] WAKE_RESTART_KEEP = 16'h0782;

	// ==========================================================
	// Selective-wake error counter limit and timing
	localparam logic [5:0]  ERR_CNT_LIMIT     = 6'h20;  // Overflow when above
	localparam int          CLK_PERIOD_NS     = 50;     // 20 MHz
	localparam int          TX_EN_TIME_NS_DEF = 4000;   // Transmitter enable time

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		CODE_NONE    = 2'h0,  // No error
		CODE_THERMAL = 2'h1,  // Thermal shutdown
		CODE_TXD_DOM = 2'h2,  // Transmit input dominant timeout
		CODE_BUS_DOM = 2'h3   // Bus dominant timeout
	} fail_code_t;

	typedef enum logic [1:0] {
		TRX_OFF    = 2'h0,
		TRX_WAKE   = 2'h1,  // Wake-capable
		TRX_RXONLY = 2'h2,
		TRX_NORMAL = 2'h3
	} trx_mode_t;

	typedef enum logic [1:0] {
		PM_NORMAL = 2'h0,
		PM_STOP   = 2'h1,
		PM_SLEEP  = 2'h2,
		PM_OTHER  = 2'h3
	} pwr_mode_t;

	typedef enum logic [2:0] {
		ST_RUN     = 3'b001,  // Transmitter enabled
		ST_FAULT   = 3'b010,  // Fault condition present
		ST_RECOVER = 3'b100   // Waiting for recessive input time
	} tx_state_t;

	typedef struct packed {
		logic        valid;  // Access strobe, one cycle
		logic        write;  // 1 = clear, 0 = read
		logic [6:0]  addr;
		logic [15:0] data;   // Clear mask on write
	} reg_acc_t;

	typedef struct packed {
		logic bus_wake_flag;
		logic timer_two_wake_flag;
		logic timer_one_wake_flag;
		logic wake_input_five_flag;
		logic wake_input_four_flag;
	} wake_ev_t;

endpackage : bus_wake_pkg

// [hw/tx_recovery_timer.sv]
// Purpose: Counts consecutive recessive transmit input cycles after a fault
// Assumes: Transmit input synchronous to clk_i
// Notes:   done_o rises on the cycle the enable time is complete

`timescale 1ns/1ps

module tx_recovery_timer import bus_wake_pkg::*; #(
	parameter int CYCLES = 80
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic resetn_i,
	// Control
	input  wire logic run_i,
	input  wire logic txd_i,
	output logic      done_o
);

	// ==========================================================
	// Elaboration check
	if (CYCLES < 1) begin : g_bad
		$error("tx_recovery_timer needs CYCLES of at least one");
	end

	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] count_reg;   // Recessive cycles seen
	logic [CW-1:0] count_next;
	logic          done_reg;    // Enable time complete
	logic          done_next;

	// Any dominant cycle restarts the count
	always_comb begin
		count_next = '0;
		done_next  = 1'b0;
		if (run_i && txd_i) begin
			done_next = (count_reg >= CW'(CYCLES - 1));
			if (!done_next) begin
				count_next = count_reg + CW'(1);
			end else begin
				count_next = count_reg;
			end
		end
	end

	// Registers only
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_reg <= '0;
			done_reg  <= 1'b0;
		end else begin
			count_reg <= count_next;
			done_reg  <= done_next;
		end
	end

	assign done_o = done_reg;

endmodule : tx_recovery_timer

// [tb/host_model.sv]
// Purpose: Host side model that reads and clears the status bank
// Assumes: Accesses launched at the falling edge, one strobe cycle each
// Notes:   Released fields are inverted so stale values never look valid

`timescale 1ns/1ps

module host_model import bus_wake_pkg::*; (
	// Clock
	input  wire logic clk_i,
	// Access port and transmit line
	output reg_acc_t  acc_o,
	output logic      txd_o
);
	// ==========================================================
	// Idle state at time zero
	initial begin
		acc_o = '0;
		txd_o = 1'b1;
	end

	// One access; strobe up for exactly one sampling edge
	task automatic access(input logic wr, input logic [6:0] a, input logic [15:0] d);
		@(negedge clk_i);
		acc_o = '{valid: 1'b1, write: wr, addr: a, data: d};
		@(negedge clk_i);
		acc_o = '{valid: 1'b0, write: ~wr, addr: ~a, data: ~d};
	endtask : access

	// Transmit level held for n cycles; recessive hold gates recovery
	task automatic set_txd(input logic v, input int n);
		@(negedge clk_i);
		txd_o = v;
		repeat (n) @(negedge clk_i);
	endtask : set_txd
endmodule : host_model

// [tb/tb.sv]
// Purpose: Self-checking bench for the bus fault and wake source status bank
// Assumes: Host model owns the access port and transmit input
// Notes:   Enable time shortened to ten cycles to keep the run brief

`timescale 1ns/1ps

module tb;
	import bus_wake_pkg::*;

	// ==========================================================
	// Signals
	localparam int TX_NS  = 500;                   // Shortened enable time
	localparam int TX_CYC = TX_NS / CLK_PERIOD_NS; // Cycles of recessive hold
	logic        clk_i, resetn_i, soft_rst, restart, fail_safe;
	pwr_mode_t   pwr_mode;
	trx_mode_t   trx_mode;
	logic        sw_en, silence, cfg_err, irq_mask, irq_pin_n;
	logic [5:0]  err_cnt;                          // Error counter value
	logic        thermal, txd_to, bus_to, bus_rec, supply_low;
	wake_ev_t    wake_ev;
	reg_acc_t    acc;
	logic        txd, irq_req, tx_en;
	logic [15:0] rd_data, e, m;
	int          err_count, n_compared, irq_seen, seed, k, n;

	// ==========================================================
	// Design, host and clock
	bus_wake_status_regs #(.TX_EN_TIME_NS(TX_NS)) dut_u (
		.clk_i(clk_i), .resetn_i(resetn_i), .acc_i(acc), .rd_data_o(rd_data),
		.soft_reset_i(soft_rst), .restart_i(restart), .fail_safe_entry_i(fail_safe),
		.pwr_mode_i(pwr_mode), .trx_mode_i(trx_mode),
		.selective_wake_enable_i(sw_en), .bus_silence_indication_i(silence),
		.sw_config_error_i(cfg_err), .sw_error_count_i(err_cnt),
		.silence_timeout_irq_mask_i(irq_mask), .interrupt_out_n_i(irq_pin_n),
		.irq_request_o(irq_req), .transceiver_thermal_shutdown_i(thermal),
		.transmit_dominant_timeout_i(txd_to), .bus_dominant_timeout_i(bus_to),
		.txd_i(txd), .bus_recessive_i(bus_rec), .supply_below_threshold_i(supply_low),
		.tx_enable_o(tx_en), .wake_ev_i(wake_ev));
	host_model host_u (.clk_i(clk_i), .acc_o(acc), .txd_o(txd));

	// Free-running 20 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// Interrupt pulses counted at the sampling edge
	always @(posedge clk_i) begin
		if (irq_req === 1'b1) irq_seen <= irq_seen + 1;
	end

	// ==========================================================
	// Helpers
	task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
		n_compared++;
		if (g !== x) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask : chk

	task automatic tick(input int c);
		repeat (c) @(negedge clk_i);
	endtask : tick

	task automatic rd(input logic [6:0] a, input logic [15:0] x);
		host_u.access(1'b0, a, 16'h0000);
		chk($sformatf("register %h", a), x, rd_data);
	endtask : rd

	task automatic clr(input logic [6:0] a, input logic [15:0] msk);
		host_u.access(1'b1, a, msk);
	endtask : clr

	// Bounded wait for the transmitter, then window check
	task automatic rec_chk();
		n = 0;
		while (tx_en !== 1'b1 && n < 60) begin
			@(negedge clk_i);
			n++;
		end
		chk("recovery cycles", 16'h0001, {15'h0, n >= TX_CYC && n <= TX_CYC + 5});
	endtask : rec_chk

	// Expected wake register image from the event set
	function automatic logic [15:0] exp_wake(input wake_ev_t w);
		exp_wake = {6'h00, w.bus_wake_flag, w.timer_two_wake_flag,
			w.timer_one_wake_flag, 2'b00, w.wake_input_five_flag,
			w.wake_input_four_flag, 3'b000};
	endfunction : exp_wake

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	// Watchdog; whole run is a few hundred cycles
	initial begin
		#1000000;
		err_count++;
		report_and_stop();
	end

	// ==========================================================
	// Main sequence
	initial begin
		{soft_rst, restart, fail_safe, sw_en, silence, cfg_err} = '0;
		{thermal, txd_to, bus_to, supply_low, irq_mask} = '0;
		{bus_rec, irq_pin_n} = 2'b11;
		err_cnt = 6'h00;
		pwr_mode = PM_NORMAL;
		trx_mode = TRX_NORMAL;
		wake_ev = '0;
		{err_count, n_compared, irq_seen} = '0;
		seed = 32'hAC0B;
		resetn_i = 1'b0;
		tick(8);
		resetn_i = 1'b1;
		rd(ADDR_BUS_FAULT, 16'h0000);
		rd(ADDR_WAKE_SOURCE, 16'h0000);
		rd(7'h10, 16'h0000);
		$display("test reset done");

		// Random wake events, random partial clears, reserved bits in mask
		for (k = 0; k < 8; k++) begin
			e = $random(seed);
			m = $random(seed);
			@(negedge clk_i);
			wake_ev = e[4:0];
			@(negedge clk_i);
			wake_ev = '0;
			tick(3);
			rd(ADDR_WAKE_SOURCE, exp_wake(e[4:0]));
			clr(ADDR_WAKE_SOURCE, m);
			rd(ADDR_WAKE_SOURCE, exp_wake(e[4:0]) & ~m);
			clr(ADDR_WAKE_SOURCE, 16'hFFFF);
		end
		wake_ev = 5'b10000; // Bus event held across its own clear
		clr(ADDR_WAKE_SOURCE, 16'h0200);
		wake_ev = '0;
		rd(ADDR_WAKE_SOURCE, 16'h0200);
		clr(ADDR_WAKE_SOURCE, 16'h0200);
		$display("test wake done");

		// Undervoltage ignored while off, acted on in receive-only
		trx_mode = TRX_OFF;
		supply_low = 1'b1;
		tick(4);
		chk("tx enable off mode", 16'h0001, {15'h0, tx_en});
		rd(ADDR_BUS_FAULT, 16'h0000);
		trx_mode = TRX_RXONLY;
		tick(3);
		chk("tx enable uv", 16'h0000, {15'h0, tx_en});
		supply_low = 1'b0;
		host_u.set_txd(1'b0, 20); // Dominant hold keeps recovery waiting
		chk("tx enable dominant", 16'h0000, {15'h0, tx_en});
		host_u.set_txd(1'b1, 0);
		rec_chk();
		rd(ADDR_BUS_FAULT, 16'h0001);
		clr(ADDR_BUS_FAULT, 16'h0001);
		rd(ADDR_BUS_FAULT, 16'h0000);
		trx_mode = TRX_NORMAL;
		$display("test undervoltage done");

		// Each failure code; fault held until its own end condition
		for (k = 1; k <= 3; k++) begin
			host_u.set_txd(k != 2, 0);
			bus_rec = (k != 3);
			thermal = (k == 1);
			txd_to = (k == 2);
			bus_to = (k == 3);
			tick(1);
			{txd_to, bus_to} = 2'b00;
			tick(20);
			chk("tx enable fault", 16'h0000, {15'h0, tx_en});
			thermal = 1'b0;
			if (k == 3) begin
				// Switch-off alone must end the bus timeout; bus stays dominant
				trx_mode = TRX_OFF;
				tick(1);
				trx_mode = TRX_NORMAL;
			end else begin
				bus_rec = 1'b1;
			end
			host_u.set_txd(1'b1, 0);
			rec_chk();
			bus_rec = 1'b1;
			rd(ADDR_BUS_FAULT, 16'(k) << 1);
			clr(ADDR_BUS_FAULT, 16'h0006);
			rd(ADDR_BUS_FAULT, 16'h0000);
		end
		$display("test failure code done");

		// Silence with selective wake off must not latch
		silence = 1'b1;
		tick(3);
		silence = 1'b0;
		rd(ADDR_BUS_FAULT, 16'h0000);
		chk("irq count off", 16'h0000, 16'(irq_seen));
		sw_en = 1'b1;
		// Mode and mask table: normal, masked, stop, sleep
		for (k = 0; k < 4; k++) begin
			n = irq_seen;
			irq_mask = (k != 1);
			pwr_mode = (k == 2) ? PM_STOP : (k == 3) ? PM_SLEEP : PM_NORMAL;
			silence = 1'b1;
			tick(3);
			silence = 1'b0;
			tick(2);
			chk("irq count", {15'h0, k[0] == 1'b0 && k != 3 ? 1'b1 : 1'b0},
				16'(irq_seen - n));
			rd(ADDR_BUS_FAULT, 16'h0010);
			clr(ADDR_BUS_FAULT, 16'h0010);
			rd(ADDR_BUS_FAULT, 16'h0010);
			irq_pin_n = 1'b0;
			tick(2);
			irq_pin_n = 1'b1;
			clr(ADDR_BUS_FAULT, 16'h0010);
			rd(ADDR_BUS_FAULT, 16'h0000);
		end
		pwr_mode = PM_NORMAL;
		$display("test silence done");

		// System error: count 32, count 33, config error, disabled
		for (k = 0; k < 4; k++) begin
			sw_en = (k != 3);
			cfg_err = (k >= 2);
			err_cnt = 6'h20 + 6'(k == 1);
			tick(3);
			{cfg_err, err_cnt} = '0;
			sw_en = 1'b1;
			rd(ADDR_BUS_FAULT, {12'h000, k == 1 || k == 2, 3'b000});
			clr(ADDR_BUS_FAULT, 16'h0008);
		end
		$display("test system error done");

		// Restart keeps low fields, soft reset and fail-safe clear
		wake_ev = 5'b11111;
		{thermal, cfg_err, silence} = 3'b111;
		trx_mode = TRX_RXONLY;
		supply_low = 1'b1;
		tick(3);
		wake_ev = '0;
		{thermal, cfg_err, silence, supply_low} = '0;
		trx_mode = TRX_NORMAL;
		restart = 1'b1;
		tick(1);
		restart = 1'b0;
		rd(ADDR_BUS_FAULT, 16'h001B);
		rd(7'h10, 16'h0000);
		rd(ADDR_WAKE_SOURCE, 16'h0380);
		soft_rst = 1'b1;
		tick(1);
		soft_rst = 1'b0;
		rd(ADDR_BUS_FAULT, 16'h0000);
		rd(ADDR_WAKE_SOURCE, 16'h0000);
		wake_ev = 5'b10101;
		tick(1);
		wake_ev = '0;
		fail_safe = 1'b1;
		tick(1);
		fail_safe = 1'b0;
		rd(ADDR_WAKE_SOURCE, 16'h0000);
		$display("test reset kinds done");
		report_and_stop();
	end
endmodule : tb
